// file: verilog/csp_cfg.svh
/*
 stack pointer unit constants: reset value, fixed upper byte, frame sizes.
 assumes inclusion by bare name from the design file.
*/
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH
`define CSP_PTR_RESET 16'h01FF
`define CSP_PAGE 8'h01
`define CSP_LOW_TOP 8'hFF
`define CSP_CALL_BYTES 3'h2
`define CSP_IRQ_BYTES 3'h5
`endif

// file: verilog/csp_pkg.sv
/*
 types for the stack pointer unit: sequencer commands and frame steps.
 assumes nothing beyond a SystemVerilog compiler.
*/
package csp_pkg;
   typedef enum logic [2:0] {
      CSP_CMD_NONE,
      CSP_CMD_PUSH,
      CSP_CMD_POP,
      CSP_CMD_CALL,
      CSP_CMD_RET,
      CSP_CMD_IRQ,
      CSP_CMD_IRET,
      CSP_CMD_RESET
   } csp_cmd_t;
   typedef enum logic [1:0] {
      CSP_IDLE,
      CSP_PUSHING,
      CSP_POPPING
   } csp_state_t;
endpackage

// file: verilog/csp_stack_pointer.sv
/*
 stack pointer unit of an 8-bit cpu core. the sequencer issues one command,
 the unit walks the stack memory a byte per cycle and reports done; the reset instruction only reloads the pointer and reports no done.
 assumes a stack memory that writes on the clock and returns read data in the
 cycle that mem_re stands, and a sequencer that pulses cmd for one cycle while busy is low.
*/
// Function
// RQ1: 16-bit pointer addresses next free byte
// RQ2: push writes at pointer, then decrements
// RQ3: pop increments first, then reads
// RQ4: 256-byte stack, upper byte fixed
// RQ5: reset and reset instruction load 01FFh
// RQ6: low byte readable and loadable directly
// RQ7: push below bottom wraps silently to top
// RQ8: pop past top wraps silently to bottom
// RQ9: interrupt stores low pc byte first
// RQ10: interrupt entry pushes context, decrements pointer
// RQ11: interrupt return pops context, increments pointer
// RQ12: call uses two bytes, interrupt five
// RQ13: single register push and pop supported
// RQ14: pc low, pc high, x, a, cc descending
`timescale 1ns/1ns
`include "csp_cfg.svh"
module csp_stack_pointer (
   input wire logic clk,
   input wire logic rst,
   input wire csp_pkg::csp_cmd_t cmd,
   input wire logic [7:0] push_data,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] x_in,
   input wire logic [7:0] a_in,
   input wire logic [7:0] cc_in,
   input wire logic low_load,
   input wire logic [7:0] low_load_data,
   input wire logic [7:0] mem_rdata,
   output logic [15:0] stack_pointer,
   output logic [15:0] mem_addr,
   output logic mem_we,
   output logic mem_re,
   output logic [7:0] mem_wdata,
   output logic busy,
   output logic done,
   output logic [7:0] pop_data,
   output logic [15:0] pc_out,
   output logic [7:0] x_out,
   output logic [7:0] a_out,
   output logic [7:0] cc_out
);
   logic [7:0] low;
   csp_pkg::csp_state_t state;
   logic [2:0] left;
   logic [2:0] idx;
   logic rd_pend;
   logic [2:0] rd_idx;
   logic [7:0] ctx [0:4];

   // the upper byte is never stored, so it cannot drift [RQ4]
   assign stack_pointer = {`CSP_PAGE, low}; // [RQ1]

   // byte order of a frame, lowest index at the highest address [RQ14]
   function automatic logic [7:0] frame_byte(input logic [2:0] i);
      case (i)
         3'h0: frame_byte = ctx[0];
         3'h1: frame_byte = ctx[1];
         3'h2: frame_byte = ctx[2];
         3'h3: frame_byte = ctx[3];
         default: frame_byte = ctx[4];
      endcase
   endfunction

   // command decode and frame walk
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= csp_pkg::CSP_IDLE;
         left <= 3'h0;
         idx <= 3'h0;
         busy <= 1'b0;
         ctx[0] <= 8'h00;
         ctx[1] <= 8'h00;
         ctx[2] <= 8'h00;
         ctx[3] <= 8'h00;
         ctx[4] <= 8'h00;
      end else begin
         case (state)
            csp_pkg::CSP_IDLE: begin
               case (cmd)
                  csp_pkg::CSP_CMD_PUSH: begin // [RQ13]
                     ctx[0] <= push_data;
                     left <= 3'h1;
                     idx <= 3'h0;
                     state <= csp_pkg::CSP_PUSHING;
                     busy <= 1'b1;
                  end
                  csp_pkg::CSP_CMD_CALL: begin // [RQ12]
                     ctx[0] <= pc_in[7:0];
                     ctx[1] <= pc_in[15:8];
                     left <= `CSP_CALL_BYTES;
                     idx <= 3'h0;
                     state <= csp_pkg::CSP_PUSHING;
                     busy <= 1'b1;
                  end
                  csp_pkg::CSP_CMD_IRQ: begin // [RQ9] [RQ10] [RQ12] [RQ14]
                     ctx[0] <= pc_in[7:0];
                     ctx[1] <= pc_in[15:8];
                     ctx[2] <= x_in;
                     ctx[3] <= a_in;
                     ctx[4] <= cc_in;
                     left <= `CSP_IRQ_BYTES;
                     idx <= 3'h0;
                     state <= csp_pkg::CSP_PUSHING;
                     busy <= 1'b1;
                  end
                  csp_pkg::CSP_CMD_POP: begin // [RQ13]
                     left <= 3'h1;
                     idx <= 3'h0;
                     state <= csp_pkg::CSP_POPPING;
                     busy <= 1'b1;
                  end
                  csp_pkg::CSP_CMD_RET: begin
                     left <= `CSP_CALL_BYTES;
                     idx <= 3'h1;
                     state <= csp_pkg::CSP_POPPING;
                     busy <= 1'b1;
                  end
                  csp_pkg::CSP_CMD_IRET: begin // [RQ11]
                     left <= `CSP_IRQ_BYTES;
                     idx <= 3'h4;
                     state <= csp_pkg::CSP_POPPING;
                     busy <= 1'b1;
                  end
                  default: begin
                  end
               endcase
            end
            csp_pkg::CSP_PUSHING: begin
               left <= left - 3'h1;
               idx <= idx + 3'h1;
               if (left == 3'h1) begin
                  state <= csp_pkg::CSP_IDLE;
                  busy <= 1'b0;
               end
            end
            csp_pkg::CSP_POPPING: begin
               // pops unwind in reverse: cc first on an interrupt return, pc high first on a return, pc low byte last
               left <= left - 3'h1;
               idx <= idx - 3'h1;
               if (left == 3'h1) begin
                  state <= csp_pkg::CSP_IDLE;
                  busy <= 1'b0;
               end
            end
            default: begin
               state <= csp_pkg::CSP_IDLE;
               busy <= 1'b0;
            end
         endcase
      end
   end

   // pointer low byte; 8-bit arithmetic gives the silent wrap for free
   always_ff @(posedge clk) begin
      if (rst) begin
         low <= `CSP_LOW_TOP; // [RQ5]
      end else if (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_RESET) begin
         low <= `CSP_LOW_TOP; // [RQ5]
      end else if (state == csp_pkg::CSP_IDLE && low_load) begin
         low <= low_load_data; // [RQ6]
      end else if (state == csp_pkg::CSP_PUSHING) begin
         low <= low - 8'h01; // [RQ2] [RQ7]
      end else if (state == csp_pkg::CSP_POPPING) begin
         low <= low + 8'h01; // [RQ3] [RQ8]
      end
   end

   // memory port: push uses the current address, pop the incremented one
   always_ff @(posedge clk) begin
      if (rst) begin
         mem_addr <= `CSP_PTR_RESET;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         mem_wdata <= 8'h00;
      end else begin
         mem_we <= 1'b0;
         mem_re <= 1'b0;
         if (state == csp_pkg::CSP_PUSHING) begin
            mem_addr <= {`CSP_PAGE, low}; // [RQ2]
            mem_we <= 1'b1;
            mem_wdata <= frame_byte(idx);
         end else if (state == csp_pkg::CSP_POPPING) begin
            mem_addr <= {`CSP_PAGE, low + 8'h01}; // [RQ3]
            mem_re <= 1'b1;
         end
      end
   end

   // read data stands while mem_re is high; route it into the frame
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_pend <= 1'b0;
         rd_idx <= 3'h0;
         done <= 1'b0;
         pop_data <= 8'h00;
         pc_out <= 16'h0000;
         x_out <= 8'h00;
         a_out <= 8'h00;
         cc_out <= 8'h00;
      end else begin
         rd_pend <= (state == csp_pkg::CSP_POPPING) && (left == 3'h1);
         rd_idx <= idx;
         done <= 1'b0;
         if (state == csp_pkg::CSP_PUSHING && left == 3'h1) begin
            done <= 1'b1;
         end
         if (mem_re) begin
            case (rd_idx)
               3'h0: begin
                  pc_out[7:0] <= mem_rdata;
                  pop_data <= mem_rdata;
               end
               3'h1: pc_out[15:8] <= mem_rdata;
               3'h2: x_out <= mem_rdata;
               3'h3: a_out <= mem_rdata;
               default: cc_out <= mem_rdata;
            endcase
            if (rd_pend) begin
               done <= 1'b1;
            end
         end
      end
   end

   a_page_fixed: assert property (@(posedge clk) disable iff (rst) // [RQ4]
      stack_pointer[15:8] == 8'h01)
      else $error("stack pointer upper byte changed");

   a_reset_value: assert property (@(posedge clk) // [RQ5]
      rst |=> stack_pointer == 16'h01FF)
      else $error("stack pointer not 01FF after reset");

   a_reset_instr: assert property (@(posedge clk) disable iff (rst) // [RQ5]
      (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_RESET)
      |=> stack_pointer == 16'h01FF)
      else $error("stack reset instruction did not restore pointer");

   a_low_load: assert property (@(posedge clk) disable iff (rst) // [RQ6]
      (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_NONE && low_load)
      |=> stack_pointer[7:0] == $past(low_load_data))
      else $error("low byte load lost");

   a_busy_refuse: assert property (@(posedge clk) disable iff (rst) // [RQ2] [RQ3]
      (busy && (cmd != csp_pkg::CSP_CMD_NONE || low_load))
      |=> stack_pointer[7:0] == $past(stack_pointer[7:0]) - 8'h01
          || stack_pointer[7:0] == $past(stack_pointer[7:0]) + 8'h01)
      else $error("command or load taken while busy");

   a_push_addr: assert property (@(posedge clk) disable iff (rst) // [RQ2] [RQ7]
      state == csp_pkg::CSP_PUSHING
      |=> mem_we && mem_addr == $past(stack_pointer)
          && stack_pointer[7:0] == $past(stack_pointer[7:0]) - 8'h01)
      else $error("push address or decrement wrong");

   a_push_one: assert property (@(posedge clk) disable iff (rst) // [RQ2] [RQ13]
      (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_PUSH && !low_load)
      |=> ##1 (done && mem_we && mem_wdata == $past(push_data, 2)
          && mem_addr == $past(stack_pointer, 2)))
      else $error("single byte push wrong");

   a_pop_addr: assert property (@(posedge clk) disable iff (rst) // [RQ3] [RQ8]
      state == csp_pkg::CSP_POPPING
      |=> mem_re && mem_addr == stack_pointer
          && stack_pointer[7:0] == $past(stack_pointer[7:0]) + 8'h01)
      else $error("pop address or increment wrong");

   a_pop_frame: assert property (@(posedge clk) disable iff (rst) // [RQ3] [RQ13]
      (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_POP)
      |=> ##1 (mem_re && stack_pointer[7:0] == $past(stack_pointer[7:0], 2) + 8'h01)
      ##1 (done && pop_data == $past(mem_rdata)))
      else $error("single byte pop wrong");

   sequence s_irq_issue;
      state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_IRQ;
   endsequence
   a_irq_frame: assert property (@(posedge clk) disable iff (rst) // [RQ9] [RQ10] [RQ12]
      s_irq_issue |=> ##1 (mem_we && mem_wdata == $past(pc_in[7:0], 2)) ##4 done
      ##0 stack_pointer[7:0] == $past(stack_pointer[7:0], 6) - 8'h05)
      else $error("interrupt frame wrong");

   a_call_frame: assert property (@(posedge clk) disable iff (rst) // [RQ12]
      (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_CALL)
      |=> ##2 done ##0 stack_pointer[7:0] == $past(stack_pointer[7:0], 3) - 8'h02)
      else $error("call did not take two bytes");

   a_ret_frame: assert property (@(posedge clk) disable iff (rst) // [RQ12]
      (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_RET)
      |=> ##2 stack_pointer[7:0] == $past(stack_pointer[7:0], 3) + 8'h02
      ##1 (done && pc_out == {$past(mem_rdata, 2), $past(mem_rdata)}))
      else $error("return did not pop two bytes");

   a_iret_frame: assert property (@(posedge clk) disable iff (rst) // [RQ11]
      (state == csp_pkg::CSP_IDLE && cmd == csp_pkg::CSP_CMD_IRET)
      |=> ##5 stack_pointer[7:0] == $past(stack_pointer[7:0], 6) + 8'h05 ##1 done)
      else $error("interrupt return did not pop five bytes");
endmodule

// file: tb/csp_stack_mem.sv
/*
 behavioural stack memory facing the stack pointer unit.
 assumes the unit's registered port: writes land on the clock, read data is taken
 in the cycle mem_re stands; low 8 address bits used.
*/
`timescale 1ns/1ns
module csp_stack_mem (
   input wire logic clk,
   input wire logic [15:0] mem_addr,
   input wire logic mem_we,
   input wire logic mem_re,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:255];
   always @(posedge clk) begin
      if (mem_we)
         mem[mem_addr[7:0]] <= mem_wdata;
   end
   // data is only good while mem_re stands; the inverse otherwise catches a late sample
   assign mem_rdata = mem_re ? mem[mem_addr[7:0]] : ~mem[mem_addr[7:0]];
endmodule

// file: tb/cpu_stack_pointer_tb.sv
/*
 self-checking bench for the stack pointer unit: command sequences and pointer checks.
 assumes csp_pkg and the design compiled first, and the stack memory model beside it.
*/
`timescale 1ns/1ns
module cpu_stack_pointer_tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   csp_pkg::csp_cmd_t cmd = csp_pkg::CSP_CMD_NONE;
   logic [7:0] push_data = 8'h00;
   logic [15:0] pc_in = 16'h0000;
   logic [7:0] x_in = 8'h11;
   logic [7:0] a_in = 8'h22;
   logic [7:0] cc_in = 8'h33;
   logic low_load = 1'b0;
   logic [7:0] low_load_data = 8'h00;
   logic [7:0] mem_rdata, mem_wdata, pop_data, x_out, a_out, cc_out;
   logic [15:0] stack_pointer, mem_addr, pc_out;
   logic mem_we, mem_re, busy, done;
   logic [7:0] exp_frame [0:4] = '{8'h78, 8'h56, 8'h11, 8'h22, 8'h33};
   int error_cnt = 0;
   int tests_run = 0;

   always #4 clk = ~clk;

   csp_stack_pointer uut (.clk(clk), .rst(rst), .cmd(cmd), .push_data(push_data),
      .pc_in(pc_in), .x_in(x_in), .a_in(a_in), .cc_in(cc_in), .low_load(low_load),
      .low_load_data(low_load_data), .mem_rdata(mem_rdata), .stack_pointer(stack_pointer),
      .mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re), .mem_wdata(mem_wdata),
      .busy(busy), .done(done), .pop_data(pop_data), .pc_out(pc_out), .x_out(x_out),
      .a_out(a_out), .cc_out(cc_out));

   csp_stack_mem u_mem (.clk(clk), .mem_addr(mem_addr), .mem_we(mem_we), .mem_re(mem_re),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   task end_of_test;
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one-cycle command pulse, then a bounded wait on done (reset instruction has none)
   task run(input csp_pkg::csp_cmd_t c, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cmd <= c;
      push_data <= d[7:0];
      pc_in <= d;
      @(posedge clk);
      cmd <= csp_pkg::CSP_CMD_NONE;
      if (c != csp_pkg::CSP_CMD_RESET) begin
         @(negedge clk);
         chk(16'(busy), 16'h0001);
         while (done !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
         end
         chk(16'(n >= 20), 16'h0000);
      end
      // the last byte of a frame lands in memory one edge after done
      @(negedge clk);
   endtask

   task load_low(input logic [7:0] d);
      @(posedge clk);
      low_load <= 1'b1;
      low_load_data <= d;
      @(posedge clk);
      low_load <= 1'b0;
      @(negedge clk);
   endtask

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk(stack_pointer, 16'h01FF);
      run(csp_pkg::CSP_CMD_PUSH, 16'h00A5);
      chk(stack_pointer, 16'h01FE);
      chk(u_mem.mem[8'hFF], 16'h00A5);
      run(csp_pkg::CSP_CMD_POP, 16'h0000);
      chk(pop_data, 16'h00A5);
      chk(stack_pointer, 16'h01FF);
      run(csp_pkg::CSP_CMD_CALL, 16'h1234);
      chk(stack_pointer, 16'h01FD);
      run(csp_pkg::CSP_CMD_IRQ, 16'h5678);
      chk(stack_pointer, 16'h01F8);
      for (int i = 0; i < 5; i++)
         chk(u_mem.mem[8'hFD - i], exp_frame[i]);
      run(csp_pkg::CSP_CMD_IRET, 16'h0000);
      chk(stack_pointer, 16'h01FD);
      chk(pc_out, 16'h5678);
      chk({x_out, a_out}, 16'h1122);
      chk(cc_out, 16'h0033);
      run(csp_pkg::CSP_CMD_RET, 16'h0000);
      chk(pc_out, 16'h1234);
      chk(stack_pointer, 16'h01FF);
      load_low(8'h00);
      chk(stack_pointer, 16'h0100);
      run(csp_pkg::CSP_CMD_PUSH, 16'h003C);
      chk(stack_pointer, 16'h01FF);
      chk(u_mem.mem[8'h00], 16'h003C);
      run(csp_pkg::CSP_CMD_POP, 16'h0000);
      chk(stack_pointer, 16'h0100);
      chk(pop_data, 16'h003C);
      load_low(8'h80);
      chk(stack_pointer, 16'h0180);
      // a reset instruction and a low-byte load offered while busy must be ignored
      @(posedge clk);
      cmd <= csp_pkg::CSP_CMD_CALL;
      pc_in <= 16'h4321;
      @(posedge clk);
      cmd <= csp_pkg::CSP_CMD_RESET;
      low_load <= 1'b1;
      @(posedge clk);
      cmd <= csp_pkg::CSP_CMD_NONE;
      low_load <= 1'b0;
      repeat (3) @(negedge clk);
      chk(stack_pointer, 16'h017E);
      chk(u_mem.mem[8'h7F], 16'h0043);
      run(csp_pkg::CSP_CMD_RESET, 16'h0000);
      chk(stack_pointer, 16'h01FF);
      end_of_test();
   end

   // the sequence needs well under 2000 cycles; allow ample margin
   initial begin
      #40000;
      error_cnt++;
      end_of_test();
   end
endmodule
